// ==== rtl/stack_irq_pkg.sv ====
// shared constants and types of the stack pointer and interrupt sequencer
// assumes one cpu clock at 20 MHz; instruction retire is reported by the core
package stack_irq_pkg;

  // stack pointer width: covers the internal sram address range
  localparam int          SP_W          = 11;
  localparam logic [15:0] SRAM_TOP_ADDR = 16'h04FF;

  // data-space offsets; io-space offsets are these minus the io base
  localparam logic [15:0] IO_BASE       = 16'h0020;
  localparam logic [15:0] SP_LOW_ADDR   = 16'h005D;
  localparam logic [15:0] SP_HIGH_ADDR  = 16'h005E;
  localparam logic [15:0] STATUS_ADDR   = 16'h005F;
  localparam logic [15:0] FLAG_ADDR     = 16'h005C;
  localparam logic [15:0] ENABLE_ADDR   = 16'h005B;

  // interrupt sources: flagged ones first, the level source last
  localparam int          N_FLAG_IRQ    = 4;
  localparam int          N_IRQ         = 5;
  localparam int          IDX_W         = 3;
  localparam logic [2:0]  LEVEL_IDX     = 3'h4;
  localparam int          GIE_BIT       = 7;

  // reset values
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [4:0]  ENABLE_RESET  = 5'h00;

  // pointer steps
  localparam logic [15:0] STEP_BYTE     = 16'h0001;
  localparam logic [15:0] STEP_ADDR     = 16'h0002;

  // operation retired by the core in the current cycle
  typedef enum logic [3:0] {
    op_other,
    op_stack_store,
    op_stack_load,
    op_pointer_call,
    op_relative_call,
    op_subroutine_exit,
    op_handler_exit,
    op_irq_mask,
    op_irq_unmask
  } op_t;

endpackage

// ==== rtl/irq_flag_cell.sv ====
// one sticky interrupt flag
// assumes set and clr are synchronous one-cycle requests
module irq_flag_cell (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  typedef struct packed {
    logic flag;
  } flag_state_t;

  flag_state_t s_r;
  flag_state_t s_nxt;

  // set wins over clear so an event in the clearing cycle is kept
  always_comb begin
    s_nxt = s_r;
    if (clr) begin
      s_nxt.flag = 1'b0;
    end
    if (set) begin
      s_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.flag;

endmodule

// ==== rtl/irq_priority_pick.sv ====
// fixed priority picker: lowest request index wins
// assumes req is a registered or settled combinational vector
module irq_priority_pick #(
  parameter int N = 5,
  parameter int W = 3
) (
  input  wire logic [N-1:0] req,
  output logic              any,
  output logic [W-1:0]      idx
);

  // scan from the top down so the lowest index is the last to write
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end

endmodule

// ==== rtl/stack_and_interrupt_sequencing.sv ====
// stack pointer and interrupt acceptance sequencing of the cpu core
// assumes the core reports each retired instruction with instr_valid and op,
// and performs the actual memory pushes and pops at stack_pointer itself
import stack_irq_pkg::*;

// Summary of operation
// - stack grows downward, pointer marks top
// - byte push lowers pointer by one
// - calls and interrupt entry lower pointer by two
// - byte pop raises pointer by one
// - both returns raise pointer by two
// - reset loads pointer with sram top address
// - pointer held as low and high byte
// - low byte at data 0x5D, io 0x3D
// - logic runs directly on cpu clock, undivided
// - writing one clears a flag, zero ignored
// - disabled source still sets and keeps flag
// - masked flags held, served by priority later
// - level source requests only while present
// - one instruction runs after handler exit
// - status register never saved nor restored
// - mask op blocks interrupts at once
// - one instruction runs after unmask op
// - acceptance at each retire, one per cycle
// - global enable bit in status gates all
module stack_and_interrupt_sequencing (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    instr_valid,
  input  wire stack_irq_pkg::op_t      op,
  input  wire logic                    mem_rd,
  input  wire logic                    mem_wr,
  input  wire logic [15:0]             mem_addr,
  input  wire logic                    io_rd,
  input  wire logic                    io_wr,
  input  wire logic [5:0]              io_addr,
  input  wire logic [7:0]              wdata,
  input  wire logic [stack_irq_pkg::N_FLAG_IRQ-1:0] irq_event,
  input  wire logic                    irq_level,
  output logic [7:0]                   rdata,
  output logic                         rdata_valid,
  output logic [15:0]                  stack_pointer,
  output logic [7:0]                   status_reg,
  output logic                         irq_take,
  output logic [stack_irq_pkg::IDX_W-1:0] irq_index
);
  import stack_irq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [SP_W-1:0]  sp;
    logic [7:0]       status;
    logic [N_IRQ-1:0] enable;
    logic [7:0]       rdata;
    logic             rvalid;
  } seq_state_t;

  seq_state_t s_r;
  seq_state_t s_nxt;

  logic [N_FLAG_IRQ-1:0] flags;
  logic [N_FLAG_IRQ-1:0] flag_clr;
  logic [N_IRQ-1:0]      pending;
  logic                  pick_any;
  logic [IDX_W-1:0]      pick_idx;
  logic                  take_ok;
  logic [15:0]           sp_wide;
  logic [15:0]           op_step;
  logic [15:0]           take_step;
  logic [15:0]           sp_sum;
  logic                  wr_sp_low;
  logic                  wr_sp_high;
  logic                  wr_status;
  logic                  wr_flag;
  logic                  wr_enable;
  logic                  rd_sp_low;
  logic                  rd_sp_high;
  logic                  rd_status;
  logic                  rd_flag;
  logic                  rd_enable;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, same register seen in data space and io space

  // io offsets are the data offsets less the io base
  function automatic logic reg_hit(input logic        mem_s,
                                   input logic        io_s,
                                   input logic [15:0] a,
                                   input logic [5:0]  ia,
                                   input logic [15:0] reg_addr);
    logic [15:0] io_full;
    io_full = reg_addr - IO_BASE;
    return (mem_s && (a == reg_addr)) || (io_s && ({10'h000, ia} == io_full));
  endfunction

  // pointer low byte decoded in both spaces
  assign wr_sp_low  = reg_hit(mem_wr, io_wr, mem_addr, io_addr, SP_LOW_ADDR);
  assign rd_sp_low  = reg_hit(mem_rd, io_rd, mem_addr, io_addr, SP_LOW_ADDR);
  assign wr_sp_high = reg_hit(mem_wr, io_wr, mem_addr, io_addr, SP_HIGH_ADDR);
  assign rd_sp_high = reg_hit(mem_rd, io_rd, mem_addr, io_addr, SP_HIGH_ADDR);
  assign wr_status  = reg_hit(mem_wr, io_wr, mem_addr, io_addr, STATUS_ADDR);
  assign rd_status  = reg_hit(mem_rd, io_rd, mem_addr, io_addr, STATUS_ADDR);
  assign wr_flag    = reg_hit(mem_wr, io_wr, mem_addr, io_addr, FLAG_ADDR);
  assign rd_flag    = reg_hit(mem_rd, io_rd, mem_addr, io_addr, FLAG_ADDR);
  assign wr_enable  = reg_hit(mem_wr, io_wr, mem_addr, io_addr, ENABLE_ADDR);
  assign rd_enable  = reg_hit(mem_rd, io_rd, mem_addr, io_addr, ENABLE_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags and priority

  // a taken flagged source has its flag cleared by the acceptance
  always_comb begin
    for (int i = 0; i < N_FLAG_IRQ; i++) begin
      flag_clr[i] = (wr_flag && wdata[i]) ||
                    (irq_take && (irq_index == IDX_W'(i)));
    end
  end

  // each cell latches its event whatever the enables say
  for (genvar g = 0; g < N_FLAG_IRQ; g++) begin : g_flag
    irq_flag_cell u_cell (
      .clk (clk),
      .rst (rst),
      .set (irq_event[g]),
      .clr (flag_clr[g]),
      .q   (flags[g])
    );
  end

  // level source has no memory: it requests only while the pin is high
  assign pending = {irq_level, flags} & s_r.enable;

  irq_priority_pick #(
    .N (N_IRQ),
    .W (IDX_W)
  ) u_pick (
    .req (pending),
    .any (pick_any),
    .idx (pick_idx)
  );

  // acceptance only at a retire boundary; mask ops and status clears act in
  // their own cycle, unmask and handler exit always let one more retire first
  always_comb begin
    take_ok = instr_valid && s_r.status[GIE_BIT];
    if ((op == op_irq_mask) || (wr_status && !wdata[GIE_BIT])) begin
      take_ok = 1'b0;
    end
    if (op == op_irq_unmask) begin
      take_ok = 1'b0;
    end
    if (op == op_handler_exit) begin
      take_ok = 1'b0;
    end
  end

  // at most one acceptance per retired instruction
  assign irq_take  = take_ok && pick_any;
  assign irq_index = pick_idx;

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer arithmetic

  // step of the retired operation; downward growth means pushes subtract
  always_comb begin
    op_step = 16'h0000;
    if (instr_valid) begin
      case (op)
        op_stack_store:     op_step = 16'h0000 - STEP_BYTE;
        op_pointer_call,
        op_relative_call:   op_step = 16'h0000 - STEP_ADDR;
        op_stack_load:      op_step = STEP_BYTE;
        op_subroutine_exit,
        op_handler_exit:    op_step = STEP_ADDR;
        default:            op_step = 16'h0000;
      endcase
    end
  end

  // entry pushes the return address after the retiring instruction's own step
  assign take_step = irq_take ? (16'h0000 - STEP_ADDR) : 16'h0000;
  assign sp_wide   = {{(16 - SP_W){1'b0}}, s_r.sp};
  assign sp_sum    = sp_wide + op_step + take_step;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // software byte writes override the arithmetic for the byte they hit
  always_comb begin
    s_nxt    = s_r;
    s_nxt.sp = sp_sum[SP_W-1:0];
    if (wr_sp_low) begin
      s_nxt.sp[7:0] = wdata;
    end
    if (wr_sp_high) begin
      s_nxt.sp[SP_W-1:8] = wdata[SP_W-9:0];
    end

    // global enable; the rest of status is left alone by entry and exit
    if (instr_valid && ((op == op_irq_unmask) || (op == op_handler_exit))) begin
      s_nxt.status[GIE_BIT] = 1'b1;
    end
    if (instr_valid && (op == op_irq_mask)) begin
      s_nxt.status[GIE_BIT] = 1'b0;
    end
    if (wr_status) begin
      s_nxt.status = wdata;
    end
    if (irq_take) begin
      s_nxt.status[GIE_BIT] = 1'b0;
    end

    if (wr_enable) begin
      s_nxt.enable = wdata[N_IRQ-1:0];
    end

    // registered read data; unmapped reads return zero
    s_nxt.rvalid = mem_rd || io_rd;
    s_nxt.rdata  = 8'h00;
    if (rd_sp_low) begin
      s_nxt.rdata = sp_wide[7:0];
    end else if (rd_sp_high) begin
      s_nxt.rdata = sp_wide[15:8];
    end else if (rd_status) begin
      s_nxt.rdata = s_r.status;
    end else if (rd_flag) begin
      s_nxt.rdata = {{(8 - N_FLAG_IRQ){1'b0}}, flags};
    end else if (rd_enable) begin
      s_nxt.rdata = {{(8 - N_IRQ){1'b0}}, s_r.enable};
    end
  end

  // single undivided cpu clock domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.sp     <= SRAM_TOP_ADDR[SP_W-1:0];
      s_r.status <= STATUS_RESET;
      s_r.enable <= ENABLE_RESET;
      s_r.rdata  <= 8'h00;
      s_r.rvalid <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign stack_pointer = sp_wide;
  assign status_reg    = s_r.status;
  assign rdata         = s_r.rdata;
  assign rdata_valid   = s_r.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic        no_sw_sp;
  logic [15:0] io_sp_low;
  assign no_sw_sp  = !wr_sp_low && !wr_sp_high;
  assign io_sp_low = SP_LOW_ADDR - IO_BASE;

  sequence s_retire(op_t o);
    instr_valid && (op == o);
  endsequence

  sequence s_plain(op_t o);
    s_retire(o) ##0 (!irq_take && no_sw_sp);
  endsequence

  chk_push_step: assert property (
    s_plain(op_stack_store) |=> stack_pointer == $past(stack_pointer) - STEP_BYTE)
    else $error("byte push did not lower the pointer by one");

  chk_call_step: assert property (
    (s_plain(op_pointer_call) or s_plain(op_relative_call))
      |=> stack_pointer == $past(stack_pointer) - STEP_ADDR)
    else $error("call did not lower the pointer by two");

  chk_entry_step: assert property (
    (instr_valid && (op == op_other) && irq_take && no_sw_sp)
      |=> (stack_pointer == $past(stack_pointer) - STEP_ADDR) && !status_reg[GIE_BIT])
    else $error("interrupt entry did not lower the pointer by two");

  chk_pop_step: assert property (
    s_plain(op_stack_load) |=> stack_pointer == $past(stack_pointer) + STEP_BYTE)
    else $error("byte pop did not raise the pointer by one");

  chk_exit_step: assert property (
    (s_plain(op_subroutine_exit) or s_plain(op_handler_exit))
      |=> stack_pointer == $past(stack_pointer) + STEP_ADDR)
    else $error("return did not raise the pointer by two");

  chk_reset_top: assert property (
    @(posedge clk) disable iff (1'b0) $fell(rst) |-> stack_pointer == SRAM_TOP_ADDR)
    else $error("pointer not at sram top after reset");

  chk_high_zero: assert property (
    stack_pointer[15:SP_W] == '0)
    else $error("unused pointer bits not zero");

  chk_low_read: assert property (
    (io_rd && !mem_rd && ({10'h000, io_addr} == io_sp_low))
      |=> rdata_valid && (rdata == $past(stack_pointer[7:0])))
    else $error("io read of pointer low byte wrong");

  chk_flag_clear: assert property (
    (wr_flag && (irq_event == '0) && !irq_take)
      |=> flags == ($past(flags) & ~$past(wdata[N_FLAG_IRQ-1:0])))
    else $error("flag write-one-to-clear misbehaved");

  chk_flag_kept: assert property (
    (irq_event != '0) |=> ((flags & $past(irq_event)) == $past(irq_event)))
    else $error("interrupt event not latched");

  chk_mask_now: assert property (
    (s_retire(op_irq_mask) ##0 !wr_status) |-> !irq_take ##1 !status_reg[GIE_BIT])
    else $error("interrupt taken at or after mask op");

  chk_one_after: assert property (
    (s_retire(op_irq_unmask) or s_retire(op_handler_exit)) |-> !irq_take)
    else $error("interrupt taken without one more instruction");

  chk_level_live: assert property (
    (irq_take && (irq_index == LEVEL_IDX)) |-> irq_level && status_reg[GIE_BIT])
    else $error("level interrupt taken without its condition");

  chk_gate_all: assert property (
    irq_take |-> instr_valid && status_reg[GIE_BIT] && pending[irq_index])
    else $error("interrupt taken while not enabled");

  chk_status_kept: assert property (
    (irq_take && !wr_status) |=> status_reg[GIE_BIT-1:0] == $past(status_reg[GIE_BIT-1:0]))
    else $error("status bits altered by interrupt entry");

endmodule

// ==== dv/test_stack_and_interrupt_sequencing.sv ====
// self-checking bench for the stack pointer and interrupt sequencer
// assumes the design package is compiled first; inputs change on falling edges
module test_stack_and_interrupt_sequencing;
  timeunit 1ns;
  timeprecision 100ps;
  import stack_irq_pkg::*;

  logic                  clk;
  logic                  rst;
  logic                  instr_valid;
  op_t                   op;
  logic                  mem_rd;
  logic                  mem_wr;
  logic [15:0]           mem_addr;
  logic                  io_rd;
  logic                  io_wr;
  logic [5:0]            io_addr;
  logic [7:0]            wdata;
  logic [N_FLAG_IRQ-1:0] irq_event;
  logic                  irq_level;
  logic [7:0]            rdata;
  logic                  rdata_valid;
  logic [15:0]           stack_pointer;
  logic [7:0]            status_reg;
  logic                  irq_take;
  logic [IDX_W-1:0]      irq_index;
  int                    n_fail;
  int                    tests_run;

  stack_and_interrupt_sequencing i_dut (
    .clk           (clk),
    .rst           (rst),
    .instr_valid   (instr_valid),
    .op            (op),
    .mem_rd        (mem_rd),
    .mem_wr        (mem_wr),
    .mem_addr      (mem_addr),
    .io_rd         (io_rd),
    .io_wr         (io_wr),
    .io_addr       (io_addr),
    .wdata         (wdata),
    .irq_event     (irq_event),
    .irq_level     (irq_level),
    .rdata         (rdata),
    .rdata_valid   (rdata_valid),
    .stack_pointer (stack_pointer),
    .status_reg    (status_reg),
    .irq_take      (irq_take),
    .irq_index     (irq_index)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz cpu clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // comparison and closing report
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // register access: io form uses the data offset minus the io base
  task automatic wr(input logic io, input logic [15:0] addr, input logic [7:0] d);
    logic [15:0] a;
    a = addr - IO_BASE;
    @(negedge clk);
    mem_wr   = ~io;
    io_wr    = io;
    mem_addr = addr;
    io_addr  = a[5:0];
    wdata    = d;
    @(negedge clk);
    mem_wr = 1'b0;
    io_wr  = 1'b0;
  endtask

  // read data stands for exactly one cycle after the strobe edge
  task automatic rd(input logic io, input logic [15:0] addr, input logic [7:0] exp);
    logic [15:0] a;
    a = addr - IO_BASE;
    @(negedge clk);
    mem_rd   = ~io;
    io_rd    = io;
    mem_addr = addr;
    io_addr  = a[5:0];
    @(negedge clk);
    mem_rd = 1'b0;
    io_rd  = 1'b0;
    check("rdata_valid", 16'(rdata_valid), 16'h0001);
    check("rdata", 16'(rdata), 16'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // retire one instruction; acceptance is combinational in the retire cycle
  task automatic retire(input op_t o, input logic tk, input logic [IDX_W-1:0] ix,
                        input logic [15:0] sp_exp);
    @(negedge clk);
    instr_valid = 1'b1;
    op          = o;
    #5;
    check("irq_take", 16'(irq_take), 16'(tk));
    if (tk) begin
      check("irq_index", 16'(irq_index), 16'(ix));
    end
    @(negedge clk);
    instr_valid = 1'b0;
    op          = op_other;
    check("stack_pointer", stack_pointer, sp_exp);
  endtask

  // one-cycle pulse on the flagged interrupt conditions
  task automatic pulse(input logic [N_FLAG_IRQ-1:0] m);
    @(negedge clk);
    irq_event = m;
    @(negedge clk);
    irq_event = '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard: a run that overstays counts as a mismatch
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    $display("wait limit reached");
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence; the pointer is tracked by hand from the documented steps
  initial begin
    n_fail      = 0;
    tests_run   = 0;
    rst         = 1'b1;
    instr_valid = 1'b0;
    op          = op_other;
    mem_rd      = 1'b0;
    mem_wr      = 1'b0;
    mem_addr    = 16'h0000;
    io_rd       = 1'b0;
    io_wr       = 1'b0;
    io_addr     = 6'h00;
    wdata       = 8'h00;
    irq_event   = '0;
    irq_level   = 1'b0;
    repeat (5) @(negedge clk);
    check("stack_pointer", stack_pointer, SRAM_TOP_ADDR);
    check("status_reg", 16'(status_reg), 16'h0000);
    rst = 1'b0;
    // pointer bytes through both address spaces, plus an unmapped hole
    rd(1'b0, SP_LOW_ADDR, 8'hFF);
    rd(1'b1, SP_LOW_ADDR, 8'hFF);
    rd(1'b1, SP_HIGH_ADDR, 8'h04);
    rd(1'b0, 16'h0040, 8'h00);
    // every instruction's stack step, downward growth from the top
    retire(op_stack_store, 1'b0, 3'h0, 16'h04FE);
    retire(op_stack_store, 1'b0, 3'h0, 16'h04FD);
    retire(op_stack_load, 1'b0, 3'h0, 16'h04FE);
    retire(op_pointer_call, 1'b0, 3'h0, 16'h04FC);
    retire(op_relative_call, 1'b0, 3'h0, 16'h04FA);
    retire(op_subroutine_exit, 1'b0, 3'h0, 16'h04FC);
    retire(op_handler_exit, 1'b0, 3'h0, 16'h04FE);
    check("status_reg", 16'(status_reg), 16'h0080);
    wr(1'b1, STATUS_ADDR, 8'h00);
    // software pointer load; unused high bits must drop
    wr(1'b0, SP_LOW_ADDR, 8'hA5);
    wr(1'b1, SP_HIGH_ADDR, 8'hFF);
    check("stack_pointer", stack_pointer, 16'h07A5);
    rd(1'b0, SP_HIGH_ADDR, 8'h07);
    // flags latch while disabled; write one clears, zero leaves
    pulse(4'b1010);
    rd(1'b1, FLAG_ADDR, 8'h0A);
    wr(1'b1, FLAG_ADDR, 8'h00);
    rd(1'b1, FLAG_ADDR, 8'h0A);
    wr(1'b0, FLAG_ADDR, 8'h08);
    rd(1'b0, FLAG_ADDR, 8'h02);
    pulse(4'b1000);
    // held while global enable is off, then served lowest index first
    wr(1'b1, ENABLE_ADDR, 8'h1F);
    retire(op_other, 1'b0, 3'h0, 16'h07A5);
    wr(1'b1, STATUS_ADDR, 8'h85);
    retire(op_other, 1'b1, 3'h1, 16'h07A3);
    check("status_reg", 16'(status_reg), 16'h0005);
    rd(1'b1, FLAG_ADDR, 8'h08);
    // exit refuses in its own cycle; the next instruction may be taken
    retire(op_handler_exit, 1'b0, 3'h0, 16'h07A5);
    check("status_reg", 16'(status_reg), 16'h0085);
    retire(op_other, 1'b1, 3'h3, 16'h07A3);
    retire(op_handler_exit, 1'b0, 3'h0, 16'h07A5);
    // mask op wins even against a request in the same cycle
    pulse(4'b0001);
    retire(op_irq_mask, 1'b0, 3'h0, 16'h07A5);
    retire(op_other, 1'b0, 3'h0, 16'h07A5);
    check("status_reg", 16'(status_reg), 16'h0005);
    retire(op_irq_unmask, 1'b0, 3'h0, 16'h07A5);
    retire(op_other, 1'b1, 3'h0, 16'h07A3);
    // level source: no request while the condition is absent
    retire(op_handler_exit, 1'b0, 3'h0, 16'h07A5);
    retire(op_other, 1'b0, 3'h0, 16'h07A5);
    irq_level = 1'b1;
    // a push retiring with an accepted entry moves three bytes
    retire(op_stack_store, 1'b1, LEVEL_IDX, 16'h07A2);
    irq_level = 1'b0;
    // a status write clearing the global enable blocks its own retire
    pulse(4'b0100);
    wr(1'b1, STATUS_ADDR, 8'h85);
    fork
      wr(1'b1, STATUS_ADDR, 8'h05);
      retire(op_other, 1'b0, 3'h0, 16'h07A2);
    join
    rd(1'b1, FLAG_ADDR, 8'h04);
    rd(1'b1, STATUS_ADDR, 8'h05);
    wrap_up();
  end

endmodule
